// file: design/hbs_channel.sv
`timescale 1ns/100ps
// one half-bridge: fault state, status code and non-overlapped drive
module hbs_channel #(
  parameter int DEAD_CYC = hbs_pkg::NONOVERLAP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic status_clear_request,
  input wire logic cmd_en,
  input wire logic cmd_hs,
  input wire logic overcurrent,
  input wire logic underload,
  input wire logic uld_shutdown,
  input wire logic force_off,
  output logic [1:0] state_code,
  output logic hs_on,
  output logic ls_on
);

  typedef enum logic [1:0] {S_OFF, S_OCS, S_UNDERLOAD, S_ON} hbs_ch_state_type;

  localparam logic [hbs_pkg::DEAD_W-1:0] DEAD_LOAD = hbs_pkg::DEAD_W'(DEAD_CYC);

  hbs_ch_state_type st_r, st_nxt;
  logic [1:0] drv_r, drv_nxt;
  logic [hbs_pkg::DEAD_W-1:0] dead_r, dead_nxt;
  logic run;
  logic [1:0] want;

  // fault priority: overcurrent beats underload, only a clear leaves a fault
  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt = S_OFF;
    end else begin
      case (st_r)
        S_OFF, S_ON: begin
          if (overcurrent) st_nxt = S_OCS;
          else if (underload && cmd_en) st_nxt = S_UNDERLOAD;
          else st_nxt = cmd_en ? S_ON : S_OFF; // [R22]
        end
        S_UNDERLOAD: begin
          if (overcurrent) st_nxt = S_OCS; // [R1]
          else if (status_clear_request && !underload) st_nxt = cmd_en ? S_ON : S_OFF;
        end
        S_OCS: begin
          // a clear that meets a live overcurrent loses, so the fault stays latched
          if (status_clear_request && !overcurrent) st_nxt = cmd_en ? S_ON : S_OFF; // [R2]
        end
        default: st_nxt = S_OFF;
      endcase
    end
  end

  // status code of the state
  always_comb begin
    case (st_r)
      S_OCS: state_code = hbs_pkg::CODE_OCS; // [R23]
      S_UNDERLOAD: state_code = hbs_pkg::CODE_UNDERLOAD;
      S_ON: state_code = hbs_pkg::CODE_ON;
      default: state_code = hbs_pkg::CODE_OFF;
    endcase
  end

  // drive from command and fault state; underload only stops it when asked
  assign run = (st_r == S_ON || (st_r == S_UNDERLOAD && !uld_shutdown)) && !force_off; // [R19]
  assign want = run ? (cmd_hs ? 2'b10 : 2'b01) : 2'b00;

  // switch off at once, switch on only after the dead time ran out
  always_comb begin
    drv_nxt = drv_r;
    dead_nxt = (dead_r == '0) ? dead_r : dead_r - 1'b1;
    if (want != drv_r) begin
      if (drv_r != 2'b00) begin
        drv_nxt = 2'b00;
        dead_nxt = DEAD_LOAD; // [R21]
      end else if (dead_r == '0) begin
        drv_nxt = want;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_OFF;
      drv_r <= 2'b00;
      dead_r <= '0;
    end else begin
      st_r <= st_nxt;
      drv_r <= drv_nxt;
      dead_r <= dead_nxt;
    end
  end

  assign hs_on = drv_r[1];
  assign ls_on = drv_r[0]; // one-hot or zero, never both [R21]

endmodule : hbs_channel

// file: design/hbs_pkg.sv
// Operation
// [R1] underload then overcurrent: report 10 then 01
// [R2] no path from overcurrent code to underload
// [R3] frame is chip select high-low-high, n x 8 clocks
// [R4] modulo 16 first 16 bits, modulo 8 after
// [R5] good frame loads last 16 bits, else discarded
// [R6] chained devices share clock phase and polarity
// [R7] select and clock parallel, data in series
// [R8] far device word shifted first, status likewise
// [R9] misordered frames of legal length are accepted
// [R10] serial out: thermal flag OR input, muxed
// [R11] master idles select high, clock and data low
// [R12] select falling shows thermal pre-bit at once
// [R13] first rising clock switches to status data
// [R14] master reads each status word to locate fault
// [R15] power-on reset clears words, outputs high impedance
// [R16] communication only with supply up and enable high
// [R17] supply fault: drivers off, words kept
// [R18] lockout enable low keeps drivers on at overvoltage
// [R19] driver state from command and fault status
// [R20] group select picks which six channels
// [R21] never both switches on, non-overlap delay
// [R22] driver stays on until commanded off or fault
// [R23] codes 00 off, 01 overcurrent, 10 underload, 11 on
// [R24] status shows channels 6-1 when bit 14 was 0
// [R25] status frozen in frame, held after clear frame
// [R26] count clock rises in frame, check at select rise
package hbs_pkg;

  localparam int NCH = 12;
  localparam int GRP = 6;
  localparam int WORD_W = 16;
  localparam int SYNC_W = 32;

  // bit counter: modulo 16 for the first word, modulo 8 afterwards
  localparam logic [3:0] FIRST_WORD_LAST = 4'hf;
  localparam logic [2:0] BYTE_ZERO = 3'h0;

  // bridge state codes
  localparam logic [1:0] CODE_OFF = 2'h0;
  localparam logic [1:0] CODE_OCS = 2'h1;
  localparam logic [1:0] CODE_UNDERLOAD = 2'h2;
  localparam logic [1:0] CODE_ON = 2'h3;

  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // non-overlap time between high and low side switching
  localparam int CLK_PERIOD_NS = 10;
  localparam int NONOVERLAP_NS = 1000;
  localparam int NONOVERLAP_CYC = (NONOVERLAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_W = 8;

  typedef struct packed {
    logic status_clear_request;
    logic grp;
    logic uldsc;
    logic [GRP-1:0] en;
    logic [GRP-1:0] cfg;
    logic overvoltage_lockout_enable;
  } hbs_cmd_type;

  typedef struct packed {
    logic ocs;
    logic psf;
    logic underload_detect;
    logic [GRP-1:0][1:0] code;
    logic tw;
  } hbs_status_type;

  typedef struct packed {
    logic chip_select_bar;
    logic sclk;
    logic si;
  } hbs_link_type;

endpackage : hbs_pkg

// file: design/hbs_spi_frame_logic.sv
`timescale 1ns/100ps
// serial command and status logic of the twelve-channel half-bridge driver
module hbs_spi_frame_logic (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic EN,
  input wire logic CHIP_SELECT_BAR,
  input wire logic SCLK,
  input wire logic SI,
  output logic SO,
  output logic SO_OE_N,
  input wire logic THERMAL_SHUTDOWN,
  input wire logic THERMAL_WARNING,
  input wire logic SUPPLY_UNDERVOLTAGE,
  input wire logic SUPPLY_OVERVOLTAGE,
  input wire logic [hbs_pkg::NCH-1:0] OVERCURRENT,
  input wire logic [hbs_pkg::NCH-1:0] UNDERLOAD_DETECT,
  output logic [hbs_pkg::NCH-1:0] HIGH_SIDE_SWITCH,
  output logic [hbs_pkg::NCH-1:0] LOW_SIDE_SWITCH,
  output logic [hbs_pkg::WORD_W-1:0] COMMAND_WORD,
  output logic [hbs_pkg::WORD_W-1:0] STATUS_WORD,
  output logic FRAME_ERROR
);

  localparam int NCH = hbs_pkg::NCH;
  localparam int GRP = hbs_pkg::GRP;

  // synchronised pins
  logic [hbs_pkg::SYNC_W-1:0] sync_q;
  hbs_pkg::hbs_link_type link_s;
  logic en_s;
  logic thermal_shutdown_flag_s;
  logic tw_s;
  logic uv_s;
  logic ov_s;
  logic [NCH-1:0] oc_s;
  logic [NCH-1:0] ul_s;

  hbs_sync #(
    .W(hbs_pkg::SYNC_W)
  ) u_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .d({EN, CHIP_SELECT_BAR, SCLK, SI, THERMAL_SHUTDOWN, THERMAL_WARNING,
        SUPPLY_UNDERVOLTAGE, SUPPLY_OVERVOLTAGE, OVERCURRENT, UNDERLOAD_DETECT}),
    .q(sync_q)
  );

  assign {en_s, link_s, thermal_shutdown_flag_s, tw_s, uv_s, ov_s, oc_s, ul_s} = sync_q;

  // frame and shift state
  logic chip_select_bar_d_r, chip_select_bar_d_nxt;
  logic sclk_d_r, sclk_d_nxt;
  logic phase_r, phase_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic pre_r, pre_nxt;
  logic [15:0] rx_r, rx_nxt;
  logic [15:0] tx_r, tx_nxt;
  logic so_r, so_nxt;
  logic so_oe_n_r, so_oe_n_nxt;
  logic ferr_r, ferr_nxt;

  // command, status and fault memory
  hbs_pkg::hbs_cmd_type cmd_r, cmd_nxt;
  hbs_pkg::hbs_status_type status_r, status_nxt;
  logic hold_r, hold_nxt;
  logic status_clear_request_r, status_clear_request_nxt;
  logic thermal_shutdown_flag_r, thermal_shutdown_flag_nxt;
  logic [NCH-1:0] en_cmd_r, en_cmd_nxt;
  logic [NCH-1:0] cfg_cmd_r, cfg_cmd_nxt;
  logic [1:0] uldsc_r, uldsc_nxt;

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic len_ok;
  logic lockout;
  logic frame_active;
  logic [NCH-1:0][1:0] codes;
  hbs_pkg::hbs_cmd_type rx_cmd;
  hbs_pkg::hbs_status_type live_status;

  // edges only count while the device is enabled
  assign cs_fall = en_s && chip_select_bar_d_r && !link_s.chip_select_bar; // [R16]
  assign cs_rise = en_s && !chip_select_bar_d_r && link_s.chip_select_bar;
  assign frame_active = en_s && !link_s.chip_select_bar;
  assign sclk_rise = frame_active && !sclk_d_r && link_s.sclk; // [R26]
  assign len_ok = phase_r && (cnt_r[2:0] == hbs_pkg::BYTE_ZERO); // [R3] [R4] [R9]
  assign rx_cmd = rx_r;

  // supply lockout; overvoltage only locks out when enabled
  assign lockout = uv_s || (ov_s && cmd_r.overvoltage_lockout_enable); // [R17] [R18]

  // status of the selected group, taken live and frozen below
  always_comb begin
    live_status = hbs_pkg::hbs_status_type'(hbs_pkg::STATUS_RESET);
    live_status.psf = uv_s || ov_s;
    live_status.tw = tw_s;
    for (int k = 0; k < GRP; k++) begin
      live_status.code[k] = codes[cmd_r.grp ? k + GRP : k]; // [R20] [R24]
      live_status.ocs = live_status.ocs || (live_status.code[k] == hbs_pkg::CODE_OCS);
      live_status.underload_detect = live_status.underload_detect ||
        (live_status.code[k] == hbs_pkg::CODE_UNDERLOAD);
    end
  end

  // serial framing: count, shift, load on a good frame
  always_comb begin
    chip_select_bar_d_nxt = link_s.chip_select_bar;
    sclk_d_nxt = link_s.sclk;
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    pre_nxt = pre_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    ferr_nxt = 1'b0;
    status_clear_request_nxt = 1'b0;
    cmd_nxt = cmd_r;
    hold_nxt = hold_r;
    en_cmd_nxt = en_cmd_r;
    cfg_cmd_nxt = cfg_cmd_r;
    uldsc_nxt = uldsc_r;
    if (cs_fall) begin
      phase_nxt = 1'b0;
      cnt_nxt = 4'h0;
      pre_nxt = 1'b1; // [R12]
      tx_nxt = status_r;
      hold_nxt = 1'b0;
    end else if (sclk_rise) begin
      rx_nxt = {rx_r[14:0], link_s.si};
      if (!phase_r) begin
        cnt_nxt = cnt_r + 4'h1; // modulo 16 for the first word [R4]
        if (cnt_r == hbs_pkg::FIRST_WORD_LAST) begin
          phase_nxt = 1'b1;
        end
      end else begin
        cnt_nxt = {1'b0, cnt_r[2:0] + 3'h1}; // modulo 8 thereafter [R4]
      end
      if (pre_r) begin
        pre_nxt = 1'b0; // [R13]
      end else begin
        tx_nxt = {tx_r[14:0], rx_r[0]}; // upstream data follows status [R7]
      end
    end else if (cs_rise) begin
      if (len_ok) begin
        cmd_nxt = rx_cmd; // [R5]
        status_clear_request_nxt = rx_cmd.status_clear_request;
        hold_nxt = rx_cmd.status_clear_request; // [R25]
        for (int k = 0; k < GRP; k++) begin
          en_cmd_nxt[rx_cmd.grp ? k + GRP : k] = rx_cmd.en[k]; // [R20]
          cfg_cmd_nxt[rx_cmd.grp ? k + GRP : k] = rx_cmd.cfg[k];
        end
        uldsc_nxt[rx_cmd.grp] = rx_cmd.uldsc;
      end else begin
        ferr_nxt = 1'b1; // whole frame dropped [R5]
      end
    end
    if (!en_s) begin
      cmd_nxt = hbs_pkg::hbs_cmd_type'(hbs_pkg::CMD_RESET);
      en_cmd_nxt = '0;
      cfg_cmd_nxt = '0;
      uldsc_nxt = 2'h0;
      hold_nxt = 1'b0;
      pre_nxt = 1'b0;
    end
  end

  // status freezes in a frame and after a clear frame until the next one
  always_comb begin
    status_nxt = status_r;
    if (!en_s) begin
      status_nxt = hbs_pkg::hbs_status_type'(hbs_pkg::STATUS_RESET);
    end else if (link_s.chip_select_bar && !hold_r && !cs_rise) begin
      status_nxt = live_status; // [R25]
    end
  end

  // thermal shutdown latches until a clear request after it has gone
  always_comb begin
    thermal_shutdown_flag_nxt = thermal_shutdown_flag_r;
    if (!en_s) thermal_shutdown_flag_nxt = 1'b0;
    else if (thermal_shutdown_flag_s) thermal_shutdown_flag_nxt = 1'b1;
    else if (status_clear_request_r) thermal_shutdown_flag_nxt = 1'b0;
  end

  // serial out: pre-bit is thermal flag OR the input, then status
  always_comb begin
    // the frame start itself selects the pre-bit, so it leaves with the enable
    so_nxt = (pre_r || cs_fall) ? (thermal_shutdown_flag_r || link_s.si) // [R10] [R12]
      : tx_r[15]; // [R11]
    so_oe_n_nxt = !frame_active; // released outside frames
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      chip_select_bar_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
      phase_r <= 1'b0;
      cnt_r <= 4'h0;
      pre_r <= 1'b0;
      rx_r <= hbs_pkg::CMD_RESET;
      tx_r <= hbs_pkg::STATUS_RESET;
      so_r <= 1'b0;
      so_oe_n_r <= 1'b1; // [R15]
      ferr_r <= 1'b0;
      cmd_r <= hbs_pkg::hbs_cmd_type'(hbs_pkg::CMD_RESET); // [R15]
      status_r <= hbs_pkg::hbs_status_type'(hbs_pkg::STATUS_RESET);
      hold_r <= 1'b0;
      status_clear_request_r <= 1'b0;
      thermal_shutdown_flag_r <= 1'b0;
      en_cmd_r <= '0;
      cfg_cmd_r <= '0;
      uldsc_r <= 2'h0;
    end else begin
      chip_select_bar_d_r <= chip_select_bar_d_nxt;
      sclk_d_r <= sclk_d_nxt;
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      so_r <= so_nxt;
      so_oe_n_r <= so_oe_n_nxt;
      ferr_r <= ferr_nxt;
      cmd_r <= cmd_nxt;
      status_r <= status_nxt;
      hold_r <= hold_nxt;
      status_clear_request_r <= status_clear_request_nxt;
      thermal_shutdown_flag_r <= thermal_shutdown_flag_nxt;
      en_cmd_r <= en_cmd_nxt;
      cfg_cmd_r <= cfg_cmd_nxt;
      uldsc_r <= uldsc_nxt;
    end
  end

  // channels; a clear request only reaches the group it selected
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    hbs_channel #(
      .DEAD_CYC(hbs_pkg::NONOVERLAP_CYC)
    ) u_ch (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .clear(!en_s),
      .status_clear_request(status_clear_request_r && (cmd_r.grp == (i >= GRP))),
      .cmd_en(en_cmd_r[i]),
      .cmd_hs(cfg_cmd_r[i]),
      .overcurrent(oc_s[i]),
      .underload(ul_s[i]),
      .uld_shutdown(uldsc_r[i / GRP]),
      .force_off(lockout || thermal_shutdown_flag_r || !en_s), // [R17] [R19]
      .state_code(codes[i]),
      .hs_on(HIGH_SIDE_SWITCH[i]),
      .ls_on(LOW_SIDE_SWITCH[i])
    );
  end

  assign SO = so_r;
  assign SO_OE_N = so_oe_n_r;
  assign COMMAND_WORD = cmd_r;
  assign STATUS_WORD = status_r;
  assign FRAME_ERROR = ferr_r;

endmodule : hbs_spi_frame_logic

// file: design/hbs_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser; the first stage feeds only the second
module hbs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule : hbs_sync

// file: testbench/hbs_master.sv
`timescale 1ns/100ps
// serial master on the far side; link clock only runs inside frames
module hbs_master (
  output logic chip_select_bar,
  output logic sclk,
  output logic si
);
  // idle levels: select high, clock and data low
  initial begin
    chip_select_bar = 1'h1;
    sclk = 1'h0;
    si = 1'h0;
  end
  // msb first, far device word first when chained
  // data moves on the falling clock, sampled on the rising one
  // so is watched live, a copy taken at the call would freeze the pre-bit
  task automatic frame(input int n, input logic [31:0] d, ref logic so,
                       ref logic [31:0] rx);
    rx = 32'h0;
    #1;
    chip_select_bar = 1'h0;
    si = d[n-1];
    for (int i = 0; i < n; i++) begin
      #62.5;
      rx[n-1-i] = so; // every word is read to locate a fault
      sclk = 1'h1;
      #62.5;
      sclk = 1'h0;
      si = (i < n - 1) ? d[n-2-i] : 1'h0;
    end
    #62.5;
    chip_select_bar = 1'h1;
    #200;
  endtask : frame
endmodule : hbs_master

// file: testbench/hbs_spi_frame_logic_asserts.sv
`timescale 1ns/100ps
// port-level checks of the serial frame logic
module hbs_chk (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic EN,
  input wire logic CHIP_SELECT_BAR,
  input wire logic SI,
  input wire logic SO,
  input wire logic SO_OE_N,
  input wire logic THERMAL_SHUTDOWN,
  input wire logic SUPPLY_UNDERVOLTAGE,
  input wire logic [hbs_pkg::NCH-1:0] HIGH_SIDE_SWITCH,
  input wire logic [hbs_pkg::NCH-1:0] LOW_SIDE_SWITCH,
  input wire logic [hbs_pkg::WORD_W-1:0] COMMAND_WORD,
  input wire logic [hbs_pkg::WORD_W-1:0] STATUS_WORD,
  input wire logic FRAME_ERROR
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // drive and word checks; windows allow for the two-flop input synchronisers
  chk_no_shoot: assert property ((HIGH_SIDE_SWITCH & LOW_SIDE_SWITCH) == 12'h000)
    else $error("both switches of one channel on");
  chk_dead_time: assert property ($rose(HIGH_SIDE_SWITCH[0]) |-> !$past(LOW_SIDE_SWITCH[0], 8))
    else $error("high side on without a gap after low side");
  chk_oe_idle: assert property ((CHIP_SELECT_BAR || !EN) [*6] |-> SO_OE_N)
    else $error("serial output driven outside a frame");
  chk_en_clears: assert property (!EN [*6] |-> COMMAND_WORD == 16'h0000
    && STATUS_WORD == 16'h0000 && LOW_SIDE_SWITCH == 12'h000)
    else $error("enable low did not clear words and drivers");
  chk_cmd_at_end: assert property ($changed(COMMAND_WORD) && EN && $past(EN, 4)
    |-> $past(CHIP_SELECT_BAR, 2))
    else $error("command changed inside a frame");
  chk_fe_end: assert property (FRAME_ERROR |-> $past(CHIP_SELECT_BAR, 2))
    else $error("frame error not at frame end");
  chk_fe_pulse: assert property (FRAME_ERROR |=> !FRAME_ERROR)
    else $error("frame error longer than one cycle");
  chk_fe_keeps: assert property (FRAME_ERROR |=> $stable(COMMAND_WORD))
    else $error("bad frame altered command");
  chk_tsd_off: assert property (THERMAL_SHUTDOWN [*8] |-> LOW_SIDE_SWITCH == 12'h000
    && HIGH_SIDE_SWITCH == 12'h000)
    else $error("drivers on during thermal shutdown");
  chk_uv_off: assert property (SUPPLY_UNDERVOLTAGE [*8] |-> LOW_SIDE_SWITCH == 12'h000)
    else $error("drivers on during undervoltage");
  chk_status_frozen: assert property (!CHIP_SELECT_BAR [*8] |-> $stable(STATUS_WORD))
    else $error("status changed inside a frame");
  chk_pre_bit: assert property ($fell(SO_OE_N) && ($past(SI, 3) || $past(THERMAL_SHUTDOWN, 8))
    |-> SO)
    else $error("pre-bit missing");
  cov_frame_err: cover property (FRAME_ERROR);
  cov_pre_high: cover property ($fell(SO_OE_N) && SO);
  cov_high_side: cover property ($rose(HIGH_SIDE_SWITCH[0]));
endmodule : hbs_chk

bind hbs_spi_frame_logic hbs_chk i_hbs_chk (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .EN(EN), .CHIP_SELECT_BAR(CHIP_SELECT_BAR),
  .SI(SI), .SO(SO), .SO_OE_N(SO_OE_N), .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN),
  .SUPPLY_UNDERVOLTAGE(SUPPLY_UNDERVOLTAGE), .HIGH_SIDE_SWITCH(HIGH_SIDE_SWITCH),
  .LOW_SIDE_SWITCH(LOW_SIDE_SWITCH), .COMMAND_WORD(COMMAND_WORD),
  .STATUS_WORD(STATUS_WORD), .FRAME_ERROR(FRAME_ERROR)
);

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb;
  localparam logic [15:0] CMD_A = 16'h1f81; // group 0 all on, low side, lockout on
  localparam logic [15:0] CMD_B = 16'h1f83; // as above, channel 1 high side
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic en = 1'h0;
  logic thermal_shutdown_flag = 1'h0;
  logic uv = 1'h0;
  logic ov = 1'h0;
  logic [11:0] oc = 12'h000;
  logic [11:0] ul = 12'h000;
  logic chip_select_bar, sclk, si, so, so_oe_n, ferr;
  logic [11:0] hs, ls;
  logic [15:0] cmd_w, status_w;
  logic [31:0] rx;
  int err_total = 0;
  int n_checks = 0;
  int fe_cnt = 0;
  int lens[6] = '{8, 12, 17, 20, 24, 32};
  int fe0;

  always #5 core_clk = ~core_clk;
  // count frame error pulses
  always @(posedge core_clk) if (ferr === 1'h1) fe_cnt++;

  hbs_spi_frame_logic i_hbs_spi_frame_logic (
    .CORE_CLK(core_clk), .RST_N(rst_n), .EN(en), .CHIP_SELECT_BAR(chip_select_bar),
    .SCLK(sclk), .SI(si), .SO(so), .SO_OE_N(so_oe_n),
    .THERMAL_SHUTDOWN(thermal_shutdown_flag), .THERMAL_WARNING(1'h0),
    .SUPPLY_UNDERVOLTAGE(uv), .SUPPLY_OVERVOLTAGE(ov), .OVERCURRENT(oc),
    .UNDERLOAD_DETECT(ul), .HIGH_SIDE_SWITCH(hs), .LOW_SIDE_SWITCH(ls),
    .COMMAND_WORD(cmd_w), .STATUS_WORD(status_w), .FRAME_ERROR(ferr)
  );
  hbs_master i_hbs_master (.chip_select_bar(chip_select_bar), .sclk(sclk), .si(si));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wcyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : wcyc

  // one frame, then settle on a clock edge
  task automatic xfer(input int n, input logic [31:0] d);
    i_hbs_master.frame(n, d, so, rx);
    wcyc(5);
  endtask : xfer

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // a hang costs one mismatch and ends the run
  initial begin
    #500000;
    err_total++;
    end_sim();
  end

  initial begin
    wcyc(3);
    check(cmd_w, 16'h0000);
    check(status_w, 16'h0000);
    check({so_oe_n, hs, ls}, 25'h1000000);
    @(posedge core_clk);
    rst_n <= 1'h1;
    en <= 1'h1;
    wcyc(10);
    xfer(16, CMD_A);
    check(cmd_w, CMD_A);
    wcyc(150);
    check({hs, ls}, 24'h00003f);
    xfer(16, CMD_A);
    check(status_w, 16'h1ffe);
    check(rx[15:0], 16'h0fff);
    // refused lengths keep the command; frames of 16 bits plus whole bytes load their last 16 bits
    for (int k = 0; k < 6; k++) begin
      fe0 = fe_cnt;
      xfer(lens[k], {16'hc3c3, (k == 5) ? CMD_A : CMD_B});
      check(fe_cnt - fe0, (k < 4) ? 1 : 0);
      check(cmd_w, (k == 4) ? CMD_B : CMD_A);
    end
    // underload then overcurrent, and overcurrent then underload
    ul[1] <= 1'h1;
    oc[0] <= 1'h1;
    wcyc(150);
    xfer(16, CMD_A);
    check(status_w, 16'hbff2);
    check(ls[0], 1'h0);
    oc[1] <= 1'h1;
    oc[0] <= 1'h0;
    ul[0] <= 1'h1;
    wcyc(20);
    xfer(16, CMD_A);
    check(status_w[12:1], 12'hff5);
    // supply faults switch drivers off but keep the words; overvoltage with lockout off leaves them on
    uv <= 1'h1;
    wcyc(10);
    check(ls, 12'h000);
    check(cmd_w, CMD_A);
    uv <= 1'h0;
    ov <= 1'h1;
    wcyc(150);
    check(ls, 12'h000);
    ov <= 1'h0;
    wcyc(150);
    check(ls, 12'h03c);
    xfer(16, 16'h1f80);
    ov <= 1'h1;
    wcyc(150);
    check(ls[5:2], 4'hf);
    ov <= 1'h0;
    // upper channel group
    xfer(16, 16'h5f80);
    wcyc(150);
    check(ls[11:6], 6'h3f);
    xfer(16, 16'h5f80);
    check(status_w, 16'h1ffe);
    // enable low clears and ignores frames
    en <= 1'h0;
    wcyc(10);
    check({cmd_w, ls, hs}, 40'h0);
    xfer(16, CMD_A);
    check(cmd_w, 16'h0000);
    en <= 1'h1;
    wcyc(10);
    // pre-bit is thermal flag or serial input
    xfer(16, 16'h9f81);
    check(rx[15], 1'h1);
    thermal_shutdown_flag <= 1'h1;
    wcyc(20);
    xfer(16, CMD_A);
    check(rx[15], 1'h1);
    check({hs, ls}, 24'h0);
    end_sim();
  end
endmodule : tb
